// ===== verilog/usb_power_regs.svh
`ifndef USB_POWER_REGS_SVH
`define USB_POWER_REGS_SVH

// Level of the power-enable pin
`define PWR_ENABLE_ON 1'b0
`define PWR_ENABLE_OFF 1'b1
// Reset values of the power pins
`define POWER_ENABLE_RST 1'b1
`define SUSPEND_IND_RST 1'b1
// Configuration memory clock divider (system clocks per half period)
`define CFG_CLK_HALF 8'h20

`endif

// ===== verilog/usb_power_pkg.sv
package usb_power_pkg;

  typedef enum logic [2:0] {
    ST_UNCONF = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_SUSPEND = 3'b100
  } power_state_e;

endpackage

// ===== verilog/sync_level.sv
`timescale 1ns/1ns
module sync_level #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] dout_nxt;

  always_comb begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= meta_nxt;
      dout <= dout_nxt;
    end
  end

endmodule // sync_level

// ===== verilog/usb_power_state_signaling.sv
`timescale 1ns/1ns
`include "usb_power_regs.svh"

// Contract
// - The reset input is active low and the block leaves reset only when it returns high.
// - Power enable is driven low while configured and not suspended.
// - Power enable is driven high while suspended or not yet configured.
// - The suspend indicator is low while the link is suspended and high otherwise.
// - The bus presence input is honoured only when the power-save option bit from memory is set.
// - With the option set, operation is normal while bus presence is high and suspend is forced while it is low.
// - During reset the memory select, clock and data pins are high impedance.
// - Out of reset the memory clock pin is driven with the configuration serial clock.
module usb_power_state_signaling #(
  parameter logic [7:0] CFG_CLK_HALF = `CFG_CLK_HALF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // USB core state
  input wire logic usbConfigured,
  input wire logic usbSuspend,
  // Option bit from configuration memory
  input wire logic powerSaveEnable,
  // Bus presence pin
  input wire logic bus_presence_sense_n,
  // Configuration memory access from the loader
  input wire logic cfgSelectReq,
  input wire logic cfgDataOutReq,
  input wire logic cfgDataOeReq,
  // Power pins
  output logic power_enable_n,
  output logic suspendInd_n,
  // Configuration memory pins
  output logic cfg_mem_select,
  output logic cfg_mem_select_oe,
  output logic cfg_mem_clock,
  output logic cfg_mem_clock_oe,
  output logic cfg_mem_io_out,
  output logic cfg_mem_io_oe,
  input wire logic cfg_mem_io_in,
  // Data read back from memory
  output logic cfgDataIn
);

  logic presenceSync;
  logic [2:0] stateSync;
  logic forcedSuspend;
  logic linkSuspend;

  usb_power_pkg::power_state_e state_r;
  usb_power_pkg::power_state_e state_nxt;
  logic powerEnable_r;
  logic powerEnable_nxt;
  logic suspendInd_r;
  logic suspendInd_nxt;
  logic [7:0] divCount_r;
  logic [7:0] divCount_nxt;
  logic memClock_r;
  logic memClock_nxt;
  logic memSelect_r;
  logic memSelect_nxt;
  logic memDataOut_r;
  logic memDataOut_nxt;
  logic memDataOe_r;
  logic memDataOe_nxt;
  logic pinsOe_r;
  logic pinsOe_nxt;
  logic dataIn_r;
  logic dataIn_nxt;

  // Two-flop sampling of the bus presence and memory data pins and the core state
  sync_level #(
    .WIDTH(4)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .din({bus_presence_sense_n, cfg_mem_io_in, usbConfigured, usbSuspend}),
    .dout({presenceSync, stateSync})
  );

  always_comb begin
    forcedSuspend = powerSaveEnable && !presenceSync;
    linkSuspend = stateSync[0] || forcedSuspend;
    state_nxt = state_r;
    case (state_r)
      usb_power_pkg::ST_UNCONF: begin
        if (linkSuspend) begin
          state_nxt = usb_power_pkg::ST_SUSPEND;
        end else if (stateSync[1]) begin
          state_nxt = usb_power_pkg::ST_ACTIVE;
        end
      end
      usb_power_pkg::ST_ACTIVE: begin
        if (linkSuspend) begin
          state_nxt = usb_power_pkg::ST_SUSPEND;
        end else if (!stateSync[1]) begin
          state_nxt = usb_power_pkg::ST_UNCONF;
        end
      end
      usb_power_pkg::ST_SUSPEND: begin
        if (!linkSuspend) begin
          state_nxt = stateSync[1] ? usb_power_pkg::ST_ACTIVE : usb_power_pkg::ST_UNCONF;
        end
      end
      default: begin
        state_nxt = usb_power_pkg::ST_UNCONF;
      end
    endcase
    // Outputs registered from the state so they switch cleanly
    powerEnable_nxt = (state_r == usb_power_pkg::ST_ACTIVE) ? `PWR_ENABLE_ON : `PWR_ENABLE_OFF;
    suspendInd_nxt = (state_r != usb_power_pkg::ST_SUSPEND);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= usb_power_pkg::ST_UNCONF;
      powerEnable_r <= `POWER_ENABLE_RST;
      suspendInd_r <= `SUSPEND_IND_RST;
    end else begin
      state_r <= state_nxt;
      powerEnable_r <= powerEnable_nxt;
      suspendInd_r <= suspendInd_nxt;
    end
  end

  // Configuration memory pins
  always_comb begin
    pinsOe_nxt = 1'b1;
    memSelect_nxt = cfgSelectReq;
    memDataOut_nxt = cfgDataOutReq;
    memDataOe_nxt = cfgDataOeReq;
    dataIn_nxt = stateSync[2];
    if (divCount_r == CFG_CLK_HALF - 8'h01) begin
      divCount_nxt = 8'h00;
      memClock_nxt = !memClock_r;
    end else begin
      divCount_nxt = divCount_r + 8'h01;
      memClock_nxt = memClock_r;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pinsOe_r <= 1'b0;
      divCount_r <= 8'h00;
      memClock_r <= 1'b0;
      memSelect_r <= 1'b0;
      memDataOut_r <= 1'b0;
      memDataOe_r <= 1'b0;
      dataIn_r <= 1'b0;
    end else begin
      pinsOe_r <= pinsOe_nxt;
      divCount_r <= divCount_nxt;
      memClock_r <= memClock_nxt;
      memSelect_r <= memSelect_nxt;
      memDataOut_r <= memDataOut_nxt;
      memDataOe_r <= memDataOe_nxt;
      dataIn_r <= dataIn_nxt;
    end
  end

  always_comb begin
    power_enable_n = powerEnable_r;
    suspendInd_n = suspendInd_r;
    cfg_mem_select = memSelect_r;
    cfg_mem_select_oe = pinsOe_r;
    cfg_mem_clock = memClock_r;
    cfg_mem_clock_oe = pinsOe_r;
    cfg_mem_io_out = memDataOut_r;
    cfg_mem_io_oe = memDataOe_r && pinsOe_r;
    cfgDataIn = dataIn_r;
  end

endmodule // usb_power_state_signaling

// ===== verif/usb_power_chk.sv
`timescale 1ns/1ns
module usb_power_chk #(parameter logic [7:0] CFG_CLK_HALF = 8'h20) (
  // Watched ports
  input wire logic clock, rst_n, usbConfigured, usbSuspend, powerSaveEnable, bus_presence_sense_n,
  input wire logic power_enable_n, suspendInd_n, cfg_mem_select_oe, cfg_mem_clock, cfg_mem_clock_oe, cfg_mem_io_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire susp = usbSuspend | (powerSaveEnable & !bus_presence_sense_n);
  wire act = usbConfigured & !susp;
  a_pwr_on: assert property (act[*6] |-> !power_enable_n) else $error("power on");
  a_pwr_off: assert property (!act[*6] |-> power_enable_n) else $error("power off");
  a_susp_low: assert property (susp[*6] |-> !suspendInd_n) else $error("suspend low");
  a_susp_high: assert property (!susp[*6] |-> suspendInd_n) else $error("suspend high");
  a_pwr_cause: assert property ($rose(power_enable_n) |-> !$past(act, 3)) else $error("power edge");
  a_tri_reset: assert property (disable iff (1'b0) !rst_n |->
    !(cfg_mem_select_oe | cfg_mem_clock_oe | cfg_mem_io_oe)) else $error("tristate");
  a_clk_drive: assert property (rst_n[*3] |-> cfg_mem_clock_oe) else $error("clock oe");
  a_clk_half: assert property ($past(cfg_mem_clock_oe, 2 * CFG_CLK_HALF) |->
    cfg_mem_clock != $past(cfg_mem_clock, CFG_CLK_HALF)) else $error("clock half");
  cover property (act[*6]);
  cover property (powerSaveEnable & !bus_presence_sense_n);
  cover property ($changed(cfg_mem_clock));
endmodule // usb_power_chk
bind usb_power_state_signaling usb_power_chk #(.CFG_CLK_HALF(CFG_CLK_HALF)) usb_power_chk_i (.*);

// ===== verif/cfg_mem_model.sv
`timescale 1ns/1ns
module cfg_mem_model (
  // Data pin
  input wire logic cfg_mem_io_out, cfg_mem_io_oe,
  output logic cfg_mem_io_in
);
  // Released pin is pulled up
  assign cfg_mem_io_in = cfg_mem_io_oe ? cfg_mem_io_out : 1'b1;
endmodule // cfg_mem_model

// ===== verif/test_usb_power_state_signaling.sv
`timescale 1ns/1ns
module test_usb_power_state_signaling;
  logic clock = 1'b0, rst_n = 1'b1, usbConfigured = 1'b0, usbSuspend = 1'b0, powerSaveEnable = 1'b0;
  logic bus_presence_sense_n = 1'b1, cfgSelectReq = 1'b0, cfgDataOutReq = 1'b0, cfgDataOeReq = 1'b0;
  logic power_enable_n, suspendInd_n, cfg_mem_select, cfg_mem_select_oe, cfg_mem_clock, cfg_mem_clock_oe;
  logic cfg_mem_io_out, cfg_mem_io_oe, cfg_mem_io_in, cfgDataIn, c0;
  int num_errors = 0, checked = 0, cycles = 0;
  usb_power_state_signaling #(.CFG_CLK_HALF(8'h02)) usb_power_state_signaling_i (.*);
  cfg_mem_model cfg_mem_model_i (.*);
  initial forever #4 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic drive(logic c, s, p, b);
    @(posedge clock);
    usbConfigured <= c;
    usbSuspend <= s;
    powerSaveEnable <= p;
    bus_presence_sense_n <= b;
    repeat (7) @(posedge clock);
    #1;
  endtask
  task automatic t_power();
    drive(1'b0, 1'b0, 1'b0, 1'b1);
    chk({power_enable_n, suspendInd_n}, 8'h03);
    drive(1'b1, 1'b0, 1'b0, 1'b0);
    chk({power_enable_n, suspendInd_n}, 8'h01);
    drive(1'b1, 1'b1, 1'b0, 1'b1);
    chk({power_enable_n, suspendInd_n}, 8'h02);
  endtask
  task automatic t_save();
    drive(1'b1, 1'b0, 1'b1, 1'b0);
    chk({power_enable_n, suspendInd_n}, 8'h02);
    drive(1'b1, 1'b0, 1'b1, 1'b1);
    chk({power_enable_n, suspendInd_n}, 8'h01);
  endtask
  task automatic t_mem();
    @(posedge clock);
    cfgSelectReq <= 1'b1;
    cfgDataOeReq <= 1'b1;
    repeat (5) @(posedge clock);
    #1 chk({cfg_mem_select, cfg_mem_select_oe, cfg_mem_io_oe, cfgDataIn}, 8'h0e);
    @(posedge clock);
    cfgDataOeReq <= 1'b0;
    cfgDataOutReq <= 1'b1;
    repeat (5) @(posedge clock);
    #1 chk({cfg_mem_io_oe, cfg_mem_io_out, cfgDataIn}, 8'h03);
    c0 = cfg_mem_clock;
    repeat (2) @(posedge clock);
    #1 chk({cfg_mem_clock_oe, cfg_mem_clock}, {7'h01, !c0});
  endtask
  initial begin
    rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    chk({power_enable_n, suspendInd_n, cfg_mem_select_oe, cfg_mem_clock_oe, cfg_mem_io_oe}, 8'h18);
    rst_n <= 1'b1;
    t_power();
    t_save();
    t_mem();
    close_out();
  end
endmodule // test_usb_power_state_signaling
